/* bench/shb_blit_asserts.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module shb_blit_asserts (
  input wire logic                  ref_clk,   // clock
  input wire logic                  sys_rst,   // reset
  input wire shb_pkg::shb_apb_req_t apb_req,   // apb in
  input wire logic [31:0]           prdata,    // read data
  input wire logic                  pready,    // ready
  input wire logic                  pslverr,   // error
  input wire shb_pkg::shb_mem_req_t mem_req,   // memory out
  input wire logic                  mem_ready, // answer
  input wire logic [31:0]           mem_rdata  // unused
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire acc   = apb_req.psel && apb_req.penable;                              // access phase
  wire bad   = acc && (apb_req.paddr > 32'h1c || apb_req.paddr[1:0] != 2'h0); // unmapped
  wire stall = mem_req.valid && !mem_ready;                                   // waiting
  AST_READY: assert property (acc |-> pready) else $error("ready low");
  AST_UNMAP: assert property (bad |-> pslverr && prdata == 32'h0) else $error("unmapped");
  AST_MAPPED: assert property (acc && !bad |-> !pslverr) else $error("false error");
  AST_QUIET: assert property (!acc |-> prdata == 32'h0 && !pslverr) else $error("idle bus");
  AST_HOLD: assert property (stall |=> mem_req.valid && $stable(mem_req.addr)) else $error("drop");
  AST_WDATA: assert property (stall && mem_req.we |=> $stable(mem_req.wdata)) else $error("wdata");
  AST_ALIGN: assert property (mem_req.valid |-> mem_req.addr[1:0] == 2'h0) else $error("align");
  AST_CALM: assert property ($fell(sys_rst) |-> !mem_req.valid) else $error("early");
  cover property (mem_req.valid && mem_req.we && mem_ready);
  cover property (bad);
  cover property (stall ##1 stall);
endmodule
bind shb_blit shb_blit_asserts i_asserts (.ref_clk(ref_clk), .sys_rst(sys_rst), .apb_req(apb_req),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_ready(mem_ready),
  .mem_rdata(mem_rdata));

/* bench/shb_mem_model.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// word memory, optional wait states
// ----------------------------------------------------------------
module shb_mem_model (
  input  wire logic                  ref_clk,   // clock
  input  wire logic                  sys_rst,   // reset
  input  wire shb_pkg::shb_mem_req_t mem_req,   // request
  input  wire logic                  slow,      // wait states
  output logic                       mem_ready, // answer
  output logic [31:0]                mem_rdata  // read data
);
  logic [31:0] mem [0:63];              // orders, bitmaps
  logic [1:0]  wait_ff;                 // wait count
  wire  [5:0]  idx = mem_req.addr[7:2]; // word index
  // inverse outside answers, so stale data never matches
  assign mem_rdata = mem_ready ? mem[idx] : ~mem[idx];
  always @(posedge ref_clk)
  begin
    mem_ready <= !sys_rst && mem_req.valid && !mem_ready && wait_ff == 2'h0;
    wait_ff   <= (sys_rst || !mem_req.valid || mem_ready) ? {slow, 1'b0} : wait_ff - {1'b0, wait_ff != 2'h0};
    if (mem_req.valid && mem_req.we && mem_ready)
      mem[idx] <= mem_req.wdata;
  end
endmodule

/* bench/tb_shb_blit.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// order bench
// ----------------------------------------------------------------
module tb_shb_blit;
  logic                  ref_clk = 1'b0; // clock
  logic                  sys_rst = 1'b1; // reset
  logic                  slow    = 1'b0; // memory waits
  shb_pkg::shb_apb_req_t req     = '0;   // apb request
  shb_pkg::shb_mem_req_t mem_req;        // memory request
  logic [31:0]           prdata, mem_rdata, q;
  logic                  pready, pslverr, mem_ready;
  int                    fails = 0, tests_run = 0;
  logic [7:0]            xs [3] = '{8'h01, 8'h11, 8'h34}; // scale bytes
  logic [7:0]            cs [3] = '{8'hf0, 8'hf0, 8'h0f}; // codes
  logic [15:0]           ws [3] = '{16'h8, 16'h7, 16'h4}; // widths
  logic [31:0]           dw [3] = '{32'hcc0000ff, 32'h980000ff, 32'h500000ff};
  shb_blit i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_ready(mem_ready), .mem_rdata(mem_rdata));
  shb_mem_model i_mem (.ref_clk(ref_clk), .sys_rst(sys_rst), .mem_req(mem_req), .slow(slow),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata));
  initial forever #50 ref_clk = ~ref_clk;
  task automatic end_sim;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, got);
    tests_run++;
    if (got !== ex)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // setup, then access held until ready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk) req <= '{1'b1, 1'b0, w, {24'h0, a}, d};
    @(posedge ref_clk) req.penable <= 1'b1;
    for (n = 0; n < 8 && (n == 0 || pready !== 1'b1); n++) @(posedge ref_clk);
    q = prdata;
    req <= '0;
    if (n == 8) chk("apb ready", 32'h1, 32'h0);
    if (n == 8) end_sim();
  endtask
  // load an order at word 0 and run it to done or fault
  task automatic run(input logic [7:0] xb, code, input logic [15:0] fw, fh);
    int n;
    i_mem.mem[0] = 32'h3705_0000;
    i_mem.mem[1] = {16'h0400, fw};
    i_mem.mem[2] = {fh, 16'h0000};
    i_mem.mem[3] = 32'h0500_0020;
    i_mem.mem[4] = {xb, 24'h000001};
    i_mem.mem[5] = 32'h0001_0000;
    i_mem.mem[6] = 32'h0600_0000;
    i_mem.mem[32] = 32'h0000_00ff;
    i_mem.mem[40] = 32'ha000_0000;
    i_mem.mem[48] = 32'h0000_0000;
    apb(1'b1, shb_pkg::REG_STATUS, 32'hf);
    apb(1'b1, shb_pkg::REG_BOOL_CODE, {24'h0, code});
    apb(1'b1, shb_pkg::REG_CTRL, 32'h1);
    for (n = 0; n < 3000; n++)
    begin
      apb(1'b0, shb_pkg::REG_STATUS, 32'h0);
      if (q[0] === 1'b0 && (q[1] | q[2]) === 1'b1) break;
    end
    if (n == 3000) chk("order end", 32'h1, 32'h0);
    if (n == 3000) end_sim();
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    apb(1'b0, shb_pkg::REG_BOOL_CODE, 32'h0);
    chk("bool reset", 32'h0000_00cc, q);
    apb(1'b0, 8'h20, 32'h0);
    apb(1'b1, shb_pkg::REG_BAND_END, 32'h7ff);
    apb(1'b1, shb_pkg::REG_DEST_PITCH, 32'h20);
    for (int i = 0; i < 3; i++)
    begin
      slow <= i[0];
      run(xs[i], cs[i], ws[i], 16'h1);
      chk("dest word", dw[i], i_mem.mem[32]);
    end
    apb(1'b1, shb_pkg::REG_BAND_END, 32'h41f);
    run(8'h01, 8'hf0, 16'h8, 16'h2);
    chk("fault flag", 32'h4, q & 32'h4);
    chk("band dest", 32'h3706_0000, i_mem.mem[0]);
    chk("dest width", 32'h0000_0008, i_mem.mem[1]);
    chk("height", 32'h0001_0000, i_mem.mem[2]);
    chk("src warp", 32'h0520_0020, i_mem.mem[3]);
    chk("scale", 32'h0100_0001, i_mem.mem[4]);
    chk("tone y", 32'h0001_0000, i_mem.mem[5]);
    end_sim();
  end
endmodule

/* src/shb_blit.sv */
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
// Functional notes
// - order: opcode 0x37, band, addresses, sizes, tone
// - band crossing rewrites only the starred operands
// - combine source, tone, destination by boolean code
// - source expanded to destination resolution first
// - halftone wraps right and bottom/top edges
// - physical dest address is logical plus base
// - destination lines stepped by banded pitch
// - frame size bounds the processed area
// - source lines stepped by src_warp only
// - x_scale low nibble, unsupported means no scaling
// - supported x codes 0,1,2,3,5,7,11,15
// - x_clip skips leftmost expanded bits
// - any y_scale 0-15 accepted
// - y_clip skips top or bottom expanded lines
// - tone remainders count to the edges
// - band fault when frame passes band end (top-down) or falls below band start (bottom-up)
// - fault rewrites band, dest, source, tone pointers
// - fault rewrites y_clip, frame_height, tone y
module shb_blit (
  input  wire logic                 ref_clk,    // 10 mhz clock
  input  wire logic                 sys_rst,    // synchronous reset, active high
  input  wire shb_pkg::shb_apb_req_t apb_req,   // apb request group
  output logic [31:0]               prdata,     // apb read data
  output logic                      pready,     // apb ready
  output logic                      pslverr,    // apb error, unmapped address
  output shb_pkg::shb_mem_req_t     mem_req,    // memory request group
  input  wire logic                 mem_ready,  // memory answer strobe
  input  wire logic [31:0]          mem_rdata   // memory read data
);

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic        b2t_ff;        // bottom_to_top_flag
  logic [3:0]  status_ff;     // busy level plus sticky status bits
  logic [31:0] order_ptr_ff;  // order location
  logic [7:0]  bool_code_ff;  // boolean code
  logic [31:0] band_base_ff;  // band_physical_base
  logic [31:0] band_end_ff;   // band_end_address
  logic [31:0] pitch_ff;      // destination pitch
  logic [15:0] tone_w_ff;     // tone_width
  logic [15:0] tone_h_ff;     // tone_height

  wire logic        acc    = apb_req.psel && apb_req.penable;
  wire logic        wr     = acc && apb_req.pwrite;
  wire logic [7:0]  ra     = apb_req.paddr[7:0];
  wire logic        hit_hi = (apb_req.paddr[31:8] == 24'h00_0000) && (ra[1:0] == 2'h0);
  wire logic        mapped = hit_hi && (ra <= shb_pkg::REG_TONE_SIZE);
  wire logic        busy   = status_ff[shb_pkg::ST_BUSY_BIT];
  wire logic        start  = wr && (ra == shb_pkg::REG_CTRL) && hit_hi
                             && apb_req.pwdata[shb_pkg::CTRL_START_BIT] && !busy;
  // setup registers are locked while an order runs
  wire logic        wr_ok  = wr && hit_hi && !busy;
  wire logic        st_clr = wr && hit_hi && (ra == shb_pkg::REG_STATUS);

  // ----------------------------------------------------------------
  // apb answer: always ready, error on unmapped words
  // ----------------------------------------------------------------
  logic [31:0] rd_mux; // read selection
  always_comb
  begin
    case (ra)
      shb_pkg::REG_CTRL:       rd_mux = {30'h0, b2t_ff, 1'b0};
      shb_pkg::REG_STATUS:     rd_mux = {28'h0, status_ff};
      shb_pkg::REG_ORDER_PTR:  rd_mux = order_ptr_ff;
      shb_pkg::REG_BOOL_CODE:  rd_mux = {24'h0, bool_code_ff};
      shb_pkg::REG_BAND_BASE:  rd_mux = band_base_ff;
      shb_pkg::REG_BAND_END:   rd_mux = band_end_ff;
      shb_pkg::REG_DEST_PITCH: rd_mux = pitch_ff;
      shb_pkg::REG_TONE_SIZE:  rd_mux = {tone_h_ff, tone_w_ff};
      default:                 rd_mux = 32'h0;
    endcase
  end
  assign prdata  = (acc && !apb_req.pwrite && mapped) ? rd_mux : 32'h0;
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // setup register writes
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      b2t_ff       <= 1'b0;
      order_ptr_ff <= shb_pkg::RST_WORD;
      bool_code_ff <= shb_pkg::RST_BOOL_CODE;
      band_base_ff <= shb_pkg::RST_WORD;
      band_end_ff  <= shb_pkg::RST_WORD;
      pitch_ff     <= shb_pkg::RST_WORD;
      tone_w_ff    <= shb_pkg::RST_TONE_DIM;
      tone_h_ff    <= shb_pkg::RST_TONE_DIM;
    end
    else if (wr_ok)
    begin
      case (ra)
        shb_pkg::REG_CTRL:       b2t_ff       <= apb_req.pwdata[shb_pkg::CTRL_B2T_BIT];
        shb_pkg::REG_ORDER_PTR:  order_ptr_ff <= apb_req.pwdata;
        shb_pkg::REG_BOOL_CODE:  bool_code_ff <= apb_req.pwdata[7:0];
        shb_pkg::REG_BAND_BASE:  band_base_ff <= apb_req.pwdata;
        shb_pkg::REG_BAND_END:   band_end_ff  <= apb_req.pwdata;
        shb_pkg::REG_DEST_PITCH: pitch_ff     <= apb_req.pwdata;
        shb_pkg::REG_TONE_SIZE:
        begin
          tone_w_ff <= apb_req.pwdata[15:0];
          tone_h_ff <= apb_req.pwdata[31:16];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // order operands and walk state
  // ----------------------------------------------------------------
  shb_pkg::shb_state_t state_ff; // sequencer state
  logic [31:0] ord_ff [0:shb_pkg::ORDER_WORDS-1]; // order image
  logic [2:0]  wcnt_ff;   // order word index
  logic [31:0] dl_ff;     // logical dest line start
  logic [31:0] sl_ff;     // source line start
  logic [31:0] hl_ff;     // tone line start at frame column 0
  logic [15:0] hy_ff;     // tone lines to edge
  logic [15:0] rows_ff;   // lines still to transfer
  logic [15:0] col_ff;    // frame column
  logic [31:0] xbit_ff;   // source bit offset in line
  logic [15:0] hx_ff;     // tone pixels to right edge
  logic [31:0] ha_ff;     // current tone bit address
  logic        sbit_ff;   // fetched source pixel
  logic        hbit_ff;   // fetched tone pixel
  logic [31:0] dword_ff;  // fetched destination word
  logic        fault_ff;  // write-back caused by band fault
  shb_pkg::shb_mem_req_t mem_ff; // memory request register

  // operand fields, big-endian byte order
  wire logic [7:0]  op_code = ord_ff[0][31:24];
  wire logic [7:0]  band    = ord_ff[0][23:16];
  wire logic [31:0] da      = {ord_ff[0][15:0], ord_ff[1][31:16]};
  wire logic [15:0] fw      = ord_ff[1][15:0];
  wire logic [15:0] fh      = ord_ff[2][31:16];
  wire logic [31:0] sa      = {ord_ff[2][15:0], ord_ff[3][31:16]};
  wire logic [15:0] sw      = ord_ff[3][15:0];
  wire logic [3:0]  x_scale = ord_ff[4][27:24];
  wire logic [3:0]  x_clip  = ord_ff[4][31:28];
  wire logic [3:0]  y_scale = ord_ff[4][19:16];
  wire logic [3:0]  y_clip  = ord_ff[4][23:20];
  wire logic [15:0] halftone_x_remaining     = ord_ff[4][15:0];
  wire logic [15:0] halftone_y_remaining     = ord_ff[5][31:16];
  wire logic [31:0] ha      = {ord_ff[5][15:0], ord_ff[6][31:16]};

  // unsupported x codes fall back to factor one
  wire logic        x_ok     = shb_pkg::SCALE_SUPPORTED[x_scale];
  wire logic [3:0]  x_last   = x_ok ? x_scale : 4'h0;
  wire logic [3:0]  x_start  = x_ok ? x_clip : 4'h0;

  // ----------------------------------------------------------------
  // address arithmetic
  // ----------------------------------------------------------------
  wire logic [31:0] sw32      = {16'h0, sw};
  wire logic [31:0] tw32      = {16'h0, tone_w_ff};
  wire logic [31:0] fw32      = {16'h0, fw};
  wire logic [31:0] tone_span = 32'((32'({16'h0, tone_h_ff}) - 32'h1) * tw32); // vertical wrap
  wire logic [31:0] band_len  = band_end_ff - band_base_ff + 32'h1;
  wire logic [31:0] row_phys  = dl_ff + band_base_ff;
  wire logic [31:0] row_end   = row_phys + fw32 - 32'h1;
  wire logic [31:0] dest_bit  = row_phys + {16'h0, col_ff};
  wire logic [31:0] src_bit   = sl_ff + xbit_ff;
  // top-down frames fault past the band end, bottom-up ones below the band start
  wire logic        band_fault = (fw != 16'h0) && (b2t_ff ? dl_ff[31] : (row_end > band_end_ff));
  wire logic        last_col  = (col_ff + 16'h1) >= fw;

  // bit select, most significant bit first within a word
  function automatic logic pick(input logic [31:0] w, input logic [31:0] b);
    pick = w[5'h1f - b[4:0]];
  endfunction
  function automatic logic [31:0] word_of(input logic [31:0] b);
    word_of = {3'h0, b[31:5], 2'h0};
  endfunction

  // ----------------------------------------------------------------
  // expansion counters and combiner
  // ----------------------------------------------------------------
  wire logic       x_load = (state_ff == shb_pkg::S_ROW);
  wire logic       x_step = (state_ff == shb_pkg::S_COL) && mem_ready;
  wire logic       y_load = (state_ff == shb_pkg::S_SETUP);
  wire logic       y_step = (state_ff == shb_pkg::S_LINE);
  wire logic       x_wrap;  // source pixel done in x
  wire logic       y_wrap;  // source line done in y
  wire logic [3:0] y_phase; // current expanded line phase
  wire logic       rop_out; // combined pixel

  shb_scale_cnt u_xcnt (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .load     (x_load),
    .load_val (x_start),
    .step     (x_step),
    .last     (x_last),
    .cnt      (),
    .wrap     (x_wrap)
  );

  // any y factor is accepted, y_clip is the starting phase
  shb_scale_cnt u_ycnt (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .load     (y_load),
    .load_val (y_clip),
    .step     (y_step),
    .last     (y_scale),
    .cnt      (y_phase),
    .wrap     (y_wrap)
  );

  shb_rop u_rop (
    .code (bool_code_ff),
    .src  (sbit_ff),
    .tone (hbit_ff),
    .dst  (pick(dword_ff, dest_bit)),
    .res  (rop_out)
  );

  // write-back image: starred operands only
  wire logic [7:0]  wb_band = b2t_ff ? band - 8'h1 : band + 8'h1;
  wire logic [31:0] wb_da   = b2t_ff ? dl_ff + band_len : dl_ff - band_len;
  wire logic [31:0] wb_word [0:shb_pkg::ORDER_WORDS-1];
  assign wb_word[0] = {op_code, wb_band, wb_da[31:16]};
  assign wb_word[1] = {wb_da[15:0], fw};
  assign wb_word[2] = {rows_ff, sl_ff[31:16]};
  assign wb_word[3] = {sl_ff[15:0], sw};
  assign wb_word[4] = {x_clip, x_scale, y_phase, y_scale, halftone_x_remaining};
  assign wb_word[5] = {hy_ff, hl_ff[31:16]};
  assign wb_word[6] = {hl_ff[15:0], ord_ff[6][15:0]};

  assign mem_req = mem_ff;

  // ----------------------------------------------------------------
  // sequencer: fetch, walk lines and columns, write back
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_ff <= shb_pkg::S_IDLE;
      mem_ff   <= '0;
      wcnt_ff  <= 3'h0;
      fault_ff <= 1'b0;
      dl_ff    <= 32'h0;
      sl_ff    <= 32'h0;
      hl_ff    <= 32'h0;
      hy_ff    <= 16'h0;
      rows_ff  <= 16'h0;
      col_ff   <= 16'h0;
      xbit_ff  <= 32'h0;
      hx_ff    <= 16'h0;
      ha_ff    <= 32'h0;
      sbit_ff  <= 1'b0;
      hbit_ff  <= 1'b0;
      dword_ff <= 32'h0;
      for (int i = 0; i < shb_pkg::ORDER_WORDS; i++)
        ord_ff[i] <= 32'h0;
    end
    else
    begin
      case (state_ff)
        shb_pkg::S_IDLE:
          if (start)
          begin
            wcnt_ff  <= 3'h0;
            fault_ff <= 1'b0;
            mem_ff   <= '{valid: 1'b1, we: 1'b0, addr: order_ptr_ff, wdata: 32'h0};
            state_ff <= shb_pkg::S_FETCH;
          end
        shb_pkg::S_FETCH:         // read the order words in turn
          if (mem_ready)
          begin
            ord_ff[wcnt_ff] <= mem_rdata;
            mem_ff.addr     <= mem_ff.addr + 32'h4;
            wcnt_ff         <= wcnt_ff + 3'h1;
            if (wcnt_ff == shb_pkg::ORDER_LAST)
            begin
              mem_ff.valid <= 1'b0;
              state_ff     <= shb_pkg::S_SETUP;
            end
          end
        shb_pkg::S_SETUP:         // corners given by the order
          if (op_code != shb_pkg::ORDER_OPCODE)
            state_ff <= shb_pkg::S_IDLE;
          else
          begin
            dl_ff    <= da;
            sl_ff    <= sa;
            hl_ff    <= ha;
            hy_ff    <= halftone_y_remaining;
            rows_ff  <= fh;
            state_ff <= shb_pkg::S_ROW;
          end
        shb_pkg::S_ROW:           // start a line or stop
          if (rows_ff == 16'h0 || fw == 16'h0)
            state_ff <= shb_pkg::S_IDLE;
          else if (band_fault)
          begin
            fault_ff <= 1'b1;
            wcnt_ff  <= 3'h0;
            mem_ff   <= '{valid: 1'b1, we: 1'b1, addr: order_ptr_ff, wdata: wb_word[0]};
            state_ff <= shb_pkg::S_WB;
          end
          else
          begin
            col_ff   <= 16'h0;
            xbit_ff  <= 32'h0;
            hx_ff    <= halftone_x_remaining;
            ha_ff    <= hl_ff;
            mem_ff   <= '{valid: 1'b1, we: 1'b0, addr: word_of(sl_ff), wdata: 32'h0};
            state_ff <= shb_pkg::S_RD_SRC;
          end
        shb_pkg::S_RD_SRC:
          if (mem_ready)
          begin
            sbit_ff     <= pick(mem_rdata, src_bit);
            mem_ff.addr <= word_of(ha_ff);
            state_ff    <= shb_pkg::S_RD_TONE;
          end
        shb_pkg::S_RD_TONE:
          if (mem_ready)
          begin
            hbit_ff     <= pick(mem_rdata, ha_ff);
            mem_ff.addr <= word_of(dest_bit);
            state_ff    <= shb_pkg::S_RD_DEST;
          end
        shb_pkg::S_RD_DEST:
          if (mem_ready)
          begin
            dword_ff     <= mem_rdata;
            mem_ff.valid <= 1'b0;
            state_ff     <= shb_pkg::S_WR_DEST;
          end
        shb_pkg::S_WR_DEST:       // merge the combined bit
        begin
          mem_ff.valid <= 1'b1;
          mem_ff.we    <= 1'b1;
          mem_ff.wdata <= dword_ff;
          mem_ff.wdata[5'h1f - dest_bit[4:0]] <= rop_out;
          state_ff     <= shb_pkg::S_COL;
        end
        shb_pkg::S_COL:           // write completes, step one column
          if (mem_ready)
          begin
            col_ff <= col_ff + 16'h1;
            if (x_wrap)
              xbit_ff <= xbit_ff + 32'h1;
            if (hx_ff <= 16'h1)               // right edge wrap
            begin
              hx_ff <= tone_w_ff;
              ha_ff <= ha_ff - (tw32 - 32'h1);
            end
            else
            begin
              hx_ff <= hx_ff - 16'h1;
              ha_ff <= ha_ff + 32'h1;
            end
            if (last_col)
            begin
              mem_ff.valid <= 1'b0;
              state_ff     <= shb_pkg::S_LINE;
            end
            else
            begin
              mem_ff.we   <= 1'b0;
              mem_ff.addr <= word_of(src_bit + (x_wrap ? 32'h1 : 32'h0));
              state_ff    <= shb_pkg::S_RD_SRC;
            end
          end
        shb_pkg::S_LINE:          // step one expanded line
        begin
          rows_ff <= rows_ff - 16'h1;
          dl_ff   <= b2t_ff ? dl_ff - pitch_ff : dl_ff + pitch_ff;
          if (y_wrap)
            sl_ff <= b2t_ff ? sl_ff - sw32 : sl_ff + sw32;
          if (hy_ff <= 16'h1)     // bottom or top edge wrap
          begin
            hy_ff <= tone_h_ff;
            hl_ff <= b2t_ff ? hl_ff + tone_span : hl_ff - tone_span;
          end
          else
          begin
            hy_ff <= hy_ff - 16'h1;
            hl_ff <= b2t_ff ? hl_ff - tw32 : hl_ff + tw32;
          end
          state_ff <= shb_pkg::S_ROW;
        end
        shb_pkg::S_WB:            // rewrite the order for the next band
          if (mem_ready)
          begin
            if (wcnt_ff == shb_pkg::ORDER_LAST)
            begin
              mem_ff   <= '0;
              state_ff <= shb_pkg::S_IDLE;
            end
            else
            begin
              wcnt_ff      <= wcnt_ff + 3'h1;
              mem_ff.addr  <= mem_ff.addr + 32'h4;
              mem_ff.wdata <= wb_word[3'(wcnt_ff + 3'h1)];
            end
          end
        default:
        begin
          mem_ff   <= '0;
          state_ff <= shb_pkg::S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status: busy level plus sticky flags, setting beats clearing
  // ----------------------------------------------------------------
  wire logic finishing = (state_ff == shb_pkg::S_ROW && (rows_ff == 16'h0 || fw == 16'h0))
                       || (state_ff == shb_pkg::S_WB && mem_ready && wcnt_ff == shb_pkg::ORDER_LAST);
  wire logic bad_op    = (state_ff == shb_pkg::S_SETUP) && (op_code != shb_pkg::ORDER_OPCODE);
  wire logic [3:0] st_set = {bad_op, finishing && fault_ff, finishing || bad_op, 1'b0};
  wire logic [3:0] st_w1c = st_clr ? {apb_req.pwdata[3:1], 1'b0} : 4'h0;
  wire logic       nxt_busy = start || (busy && !(finishing || bad_op));

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      status_ff <= 4'h0;
    else
      status_ff <= {(status_ff[3:1] & ~st_w1c[3:1]) | st_set[3:1], nxt_busy};
  end

endmodule

/* src/shb_pkg.sv */
package shb_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the apb port)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL       = 8'h00; // start pulse, bottom_to_top_flag
  localparam logic [7:0] REG_STATUS     = 8'h04; // busy / done / band fault / bad opcode
  localparam logic [7:0] REG_ORDER_PTR  = 8'h08; // byte address of the order in memory
  localparam logic [7:0] REG_BOOL_CODE  = 8'h0c; // three-operand boolean code
  localparam logic [7:0] REG_BAND_BASE  = 8'h10; // band_physical_base
  localparam logic [7:0] REG_BAND_END   = 8'h14; // band_end_address
  localparam logic [7:0] REG_DEST_PITCH = 8'h18; // destination line pitch in bits
  localparam logic [7:0] REG_TONE_SIZE  = 8'h1c; // tone_width [15:0], tone_height [31:16]

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_B2T_BIT    = 1;
  localparam int ST_BUSY_BIT     = 0;
  localparam int ST_DONE_BIT     = 1;
  localparam int ST_FAULT_BIT    = 2;
  localparam int ST_BADOP_BIT    = 3;
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [7:0]  RST_BOOL_CODE = 8'hcc;         // plain copy of tone
  localparam logic [15:0] RST_TONE_DIM  = 16'h0001;

  // ----------------------------------------------------------------
  // order layout
  // ----------------------------------------------------------------
  localparam logic [7:0] ORDER_OPCODE = 8'h37;
  localparam int         ORDER_WORDS  = 7;             // 26 bytes, padded to 28
  localparam logic [2:0] ORDER_LAST   = 3'h6;
  localparam logic [15:0] SCALE_SUPPORTED = 16'h88af;  // codes 0,1,2,3,5,7,11,15

  // ----------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } shb_apb_req_t;

  typedef struct packed {
    logic        valid;   // request held until mem_ready
    logic        we;
    logic [31:0] addr;    // byte address, word aligned
    logic [31:0] wdata;
  } shb_mem_req_t;

  typedef enum logic [3:0] {
    S_IDLE    = 4'b0000,
    S_FETCH   = 4'b0001,
    S_SETUP   = 4'b0010,
    S_ROW     = 4'b0011,
    S_RD_SRC  = 4'b0100,
    S_RD_TONE = 4'b0101,
    S_RD_DEST = 4'b0110,
    S_WR_DEST = 4'b0111,
    S_COL     = 4'b1000,
    S_LINE    = 4'b1001,
    S_WB      = 4'b1010
  } shb_state_t;

endpackage

/* src/shb_rop.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------------
// three-operand boolean combiner
// ------------------------------------------------------------------
module shb_rop (
  input  wire logic [7:0] code,   // truth table, index {s,h,d}
  input  wire logic       src,    // expanded source pixel
  input  wire logic       tone,   // halftone pixel
  input  wire logic       dst,    // destination pixel
  output wire logic       res     // combined pixel
);
  // one table bit per operand combination
  assign res = code[{src, tone, dst}];
endmodule

/* src/shb_scale_cnt.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------------
// expansion phase counter: counts 0..last, wraps with a pulse
// ------------------------------------------------------------------
module shb_scale_cnt (
  input  wire logic       ref_clk,  // clock
  input  wire logic       sys_rst,  // synchronous reset
  input  wire logic       load,     // take load_val
  input  wire logic [3:0] load_val, // starting phase (clip)
  input  wire logic       step,     // advance one expanded pixel
  input  wire logic [3:0] last,     // factor minus one
  output wire logic [3:0] cnt,      // current phase
  output wire logic       wrap      // step that ends a source pixel
);
  logic [3:0] cnt_ff;  // phase register
  logic [3:0] nxt_cnt; // next phase

  assign wrap    = step && (cnt_ff >= last);
  assign nxt_cnt = load ? load_val : (wrap ? 4'h0 : (step ? cnt_ff + 4'h1 : cnt_ff));
  assign cnt     = cnt_ff;

  // phase update
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      cnt_ff <= 4'h0;
    else
      cnt_ff <= nxt_cnt;
  end
endmodule
